// >>> design/dpd_loop.sv
// Digital loop: phase detector, profile-based loop filter, synthesizer accumulator, holdover and outputs.
// Assumes reference pins are asynchronous; the system clock source or its internal multiplier lies outside.
//
// Summary of operation
// - Synthesizer runs from the system clock source.
// - Detector feeds filter; filter feeds synthesizer, feedback.
// - Output frequency is tuning word over 2^48.
// - Edge offset measured in 0.5 ps units, one clock period per step.
// - Programmable coefficients set loop bandwidth.
// - Four output pairs, each with divider.
// - Processor reads the active tuning word.
// - Processor writes a tuning word, forcing frequency outside lock.
// - Closed loop aligns feedback frequency and edges.
// - One of eight references selected.
// - Reference loss enters holdover automatically.
// - Holdover word from processor or averager.
// - Block average of applied tuning words kept.
// - Eight profiles; processor switches between them.
`timescale 1ns/10ps
module dpd_loop
	import dpd_pkg::*;
#(
	parameter int LOSS_CYCLES = dpd_pkg::DPD_LOSS_CYCLES,
	parameter int FB_DIV = 1000
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// References and outputs
	input wire logic [dpd_pkg::DPD_NUM_REF-1:0] refIn,
	input wire logic [dpd_pkg::DPD_NUM_OUT-1:0] outEnable,
	input wire logic [dpd_pkg::DPD_NUM_OUT*dpd_pkg::DPD_DIV_W-1:0] outDivide,
	output logic [dpd_pkg::DPD_NUM_OUT-1:0] outClk,
	// Processor side
	input wire dpd_pkg::dpd_ctrl_t ctrl,
	output dpd_pkg::dpd_stat_t stat,
	// Synthesizer phase to the converter
	output logic [dpd_pkg::DPD_FTW_W-1:0] synthPhase
);
	import dpd_pkg::*;

	initial begin
		if (LOSS_CYCLES < 2 || FB_DIV < 1 || FB_DIV >= (1 << DPD_FB_DIV_W)) begin
			$error("dpd_loop: unsupported parameter value");
		end
	end

	// ****************************************
	// Reference synchronisation and selection
	// ****************************************
	logic [DPD_NUM_REF-1:0] refMeta_r;
	logic [DPD_NUM_REF-1:0] refSync_r;
	logic refPrev_r;
	logic refSel;
	logic refEdge;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refMeta_r <= '0;
			refSync_r <= '0;
		end else begin
			refMeta_r <= refIn;
			refSync_r <= refMeta_r;
		end
	end

	assign refSel = refSync_r[ctrl.selRef];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refPrev_r <= 1'b0;
		end else begin
			refPrev_r <= refSel;
		end
	end

	assign refEdge = refSel & ~refPrev_r;

	// ****************************************
	// Reference loss monitor
	// ****************************************
	logic [31:0] lossCnt_r;
	logic refPresent_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lossCnt_r <= '0;
			refPresent_r <= 1'b0;
		end else if (refEdge) begin
			lossCnt_r <= '0;
			refPresent_r <= 1'b1;
		end else if (lossCnt_r >= 32'(LOSS_CYCLES - 1)) begin
			refPresent_r <= 1'b0;
		end else begin
			lossCnt_r <= lossCnt_r + 32'h1;
		end
	end

	// ****************************************
	// Synthesizer accumulator
	// ****************************************
	logic [DPD_FTW_W-1:0] ftwActive_r;
	logic [DPD_FTW_W-1:0] acc_r;
	logic carry_r;
	logic [DPD_FTW_W:0] accSum;

	// Output frequency = ftw / 2^48 * f_clk; sum wraps modulo 2^48.
	assign accSum = {1'b0, acc_r} + {1'b0, ftwActive_r};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_r <= '0;
			carry_r <= 1'b0;
		end else begin
			acc_r <= accSum[DPD_FTW_W-1:0];
			carry_r <= accSum[DPD_FTW_W];
		end
	end

	// ****************************************
	// Feedback divider from synthesizer carry
	// ****************************************
	logic [DPD_FB_DIV_W-1:0] fbCnt_r;
	logic fbEdge_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fbCnt_r <= '0;
			fbEdge_r <= 1'b0;
		end else begin
			fbEdge_r <= 1'b0;
			if (carry_r) begin
				if (fbCnt_r >= DPD_FB_DIV_W'(FB_DIV - 1)) begin
					fbCnt_r <= '0;
					fbEdge_r <= 1'b1;
				end else begin
					fbCnt_r <= fbCnt_r + 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Phase detector
	// ****************************************
	// Offset counts in 0.5 ps units, one clock period added per cycle between the two edges.
	logic signed [DPD_PHASE_W-1:0] pdTimer_r;
	logic signed [DPD_PHASE_W-1:0] pdErr_r;
	logic pdValid_r;
	logic refSeen_r;
	logic fbSeen_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pdTimer_r <= '0;
			pdErr_r <= '0;
			pdValid_r <= 1'b0;
			refSeen_r <= 1'b0;
			fbSeen_r <= 1'b0;
		end else begin
			pdValid_r <= 1'b0;
			if (refEdge && fbEdge_r) begin
				pdErr_r <= '0;
				pdValid_r <= 1'b1;
				refSeen_r <= 1'b0;
				fbSeen_r <= 1'b0;
				pdTimer_r <= '0;
			end else if ((refEdge && fbSeen_r) || (fbEdge_r && refSeen_r)) begin
				// Positive error: feedback late, so the loop speeds up.
				pdErr_r <= refSeen_r ? pdTimer_r : -pdTimer_r;
				pdValid_r <= 1'b1;
				refSeen_r <= 1'b0;
				fbSeen_r <= 1'b0;
				pdTimer_r <= '0;
			end else if (refEdge || fbEdge_r) begin
				refSeen_r <= refEdge;
				fbSeen_r <= fbEdge_r;
				pdTimer_r <= '0;
			end else if (refSeen_r || fbSeen_r) begin
				pdTimer_r <= pdTimer_r + DPD_PD_STEP;
			end
		end
	end

	// ****************************************
	// Profile store
	// ****************************************
	dpd_prof_t prof_r [DPD_NUM_PROF];
	dpd_prof_t profAct;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DPD_NUM_PROF; i++) begin
				prof_r[i] <= '{propShift: 6'h10, intShift: 6'h18};
			end
		end else if (ctrl.wrProf) begin
			prof_r[ctrl.wrProfIdx] <= ctrl.wrProfData;
		end
	end

	assign profAct = prof_r[ctrl.selProf];

	// ****************************************
	// Loop filter
	// ****************************************
	dpd_state_t state_r;
	logic signed [DPD_FTW_W-1:0] integ_r;
	logic signed [DPD_FTW_W-1:0] errExt;
	logic signed [DPD_FTW_W-1:0] filtOut;

	function automatic logic signed [DPD_FTW_W-1:0] shiftGain(input logic signed [DPD_FTW_W-1:0] v,
			input logic [5:0] s);
		shiftGain = (v <<< 24) >>> s;
	endfunction

	assign errExt = DPD_FTW_W'(pdErr_r);
	assign filtOut = integ_r + shiftGain(errExt, profAct.propShift);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			integ_r <= $signed(DPD_FTW_RST);
		end else if (state_r == DPD_ST_LOCK && pdValid_r) begin
			integ_r <= integ_r + shiftGain(errExt, profAct.intShift);
		end else if (state_r != DPD_ST_LOCK) begin
			// Seed with the running word so relock starts without a jump.
			integ_r <= $signed(ftwActive_r);
		end
	end

	// ****************************************
	// Mode control
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= DPD_ST_FREE;
		end else begin
			case (state_r)
				DPD_ST_FREE: begin
					if (refPresent_r && !ctrl.forceHold) begin
						state_r <= DPD_ST_LOCK;
					end
				end
				DPD_ST_LOCK: begin
					if (ctrl.forceHold || (!refPresent_r && ctrl.autoHold)) begin
						state_r <= DPD_ST_HOLD;
					end else if (!refPresent_r) begin
						state_r <= DPD_ST_FREE;
					end
				end
				DPD_ST_HOLD: begin
					if (refPresent_r && !ctrl.forceHold) begin
						state_r <= DPD_ST_LOCK;
					end
				end
				default: begin
					state_r <= DPD_ST_FREE;
				end
			endcase
		end
	end

	// ****************************************
	// Tuning word averager
	// ****************************************
	// Piecewise average: sums 2^N words per block; long blocks trade response for smoothness.
	logic [DPD_FTW_W+DPD_AVG_LOG2-1:0] avgSum_r;
	logic [DPD_AVG_LOG2-1:0] avgCnt_r;
	logic [DPD_FTW_W-1:0] avgOut_r;
	logic [DPD_FTW_W+DPD_AVG_LOG2-1:0] avgNext;

	assign avgNext = avgSum_r + (DPD_FTW_W+DPD_AVG_LOG2)'(ftwActive_r);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			avgSum_r <= '0;
			avgCnt_r <= '0;
			avgOut_r <= DPD_FTW_RST;
		end else if (state_r == DPD_ST_LOCK && pdValid_r) begin
			avgCnt_r <= avgCnt_r + 1'b1;
			if (avgCnt_r == '1) begin
				avgOut_r <= avgNext[DPD_FTW_W+DPD_AVG_LOG2-1:DPD_AVG_LOG2];
				avgSum_r <= '0;
			end else begin
				avgSum_r <= avgNext;
			end
		end
	end

	// ****************************************
	// Active tuning word
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ftwActive_r <= DPD_FTW_RST;
		end else if (ctrl.wrFtw && state_r != DPD_ST_LOCK) begin
			ftwActive_r <= ctrl.ftwData;
		end else if (state_r == DPD_ST_HOLD && ctrl.holdUseAvg) begin
			ftwActive_r <= avgOut_r;
		end else if (state_r == DPD_ST_LOCK) begin
			ftwActive_r <= filtOut;
		end
	end

	// ****************************************
	// Output pairs
	// ****************************************
	for (genvar g = 0; g < DPD_NUM_OUT; g++) begin : gOut
		dpd_out_div #(.DIV_W(DPD_DIV_W)) uDiv (
			.clk_sys(clk_sys),
			.rst(rst),
			.enable(outEnable[g]),
			.divide(outDivide[g*DPD_DIV_W +: DPD_DIV_W]),
			.tickIn(carry_r),
			.clkOut(outClk[g])
		);
	end

	// ****************************************
	// Status
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stat <= '0;
			synthPhase <= '0;
		end else begin
			stat.ftwActive <= ftwActive_r;
			stat.ftwAverage <= avgOut_r;
			stat.refPresent <= refPresent_r;
			stat.inHold <= (state_r == DPD_ST_HOLD);
			stat.locked <= (state_r == DPD_ST_LOCK);
			synthPhase <= acc_r;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_hold_on_loss: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == DPD_ST_LOCK && !refPresent_r && ctrl.autoHold) |=> state_r == DPD_ST_HOLD)
		else $error("holdover not entered on reference loss");
	// The edge that releases reset still finds every flop held, so attempts start only once reset has been seen low.
	a_ftw_readback: assert property (@(posedge clk_sys) disable iff (rst)
		!rst |=> stat.ftwActive == $past(ftwActive_r))
		else $error("readback word mismatch");
	a_ftw_force: assert property (@(posedge clk_sys) disable iff (rst)
		(ctrl.wrFtw && state_r != DPD_ST_LOCK) |=> ftwActive_r == $past(ctrl.ftwData))
		else $error("written word not applied");
	a_acc_step: assert property (@(posedge clk_sys) disable iff (rst)
		!rst |=> acc_r == DPD_FTW_W'($past(acc_r) + $past(ftwActive_r)))
		else $error("accumulator step wrong");
	a_hold_avg: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == DPD_ST_HOLD && ctrl.holdUseAvg && !ctrl.wrFtw) |=> ftwActive_r == $past(avgOut_r))
		else $error("holdover word not from averager");
	a_loss_time: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(refPresent_r) |-> lossCnt_r == 32'(LOSS_CYCLES - 1))
		else $error("reference loss flagged early");
	a_lock_filter: assert property (@(posedge clk_sys) disable iff (rst)
		(state_r == DPD_ST_LOCK && !ctrl.wrFtw && $past(state_r) == DPD_ST_LOCK)
			|=> ftwActive_r == $past(filtOut))
		else $error("locked word not from filter");
	a_fb_period: assert property (@(posedge clk_sys) disable iff (rst)
		fbEdge_r |-> $past(carry_r))
		else $error("feedback edge without carry");

endmodule

// >>> design/dpd_pkg.sv
// Package for the digitally disciplined synthesizer loop: widths, profile layout and reset values.
// Assumes a single system clock domain; every other clock arrives as a pin and is synchronised.
package dpd_pkg;

	// ****************************************
	// Widths and counts
	// ****************************************
	localparam int DPD_FTW_W = 48;
	localparam int DPD_PHASE_W = 32;
	localparam int DPD_NUM_REF = 8;
	localparam int DPD_NUM_PROF = 8;
	localparam int DPD_NUM_OUT = 4;
	localparam int DPD_DIV_W = 8;
	localparam int DPD_AVG_LOG2 = 4;
	localparam int DPD_FB_DIV_W = 16;

	// Phase detector resolution in femtoseconds (0.5 ps) and clock period in femtoseconds.
	localparam longint DPD_PD_RES_FS = 64'd500;
	localparam longint DPD_CLK_PERIOD_FS = 64'd40000000;
	// Detector counts added per clock cycle.
	localparam logic [DPD_PHASE_W-1:0] DPD_PD_STEP = DPD_PHASE_W'(DPD_CLK_PERIOD_FS / DPD_PD_RES_FS);

	// Reference loss: cycles without a reference edge before holdover is entered.
	localparam int DPD_LOSS_CYCLES = 4096;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [DPD_FTW_W-1:0] DPD_FTW_RST = 48'h1000_0000_0000;
	localparam logic [2:0] DPD_PROF_RST = 3'h0;
	localparam logic [2:0] DPD_REF_RST = 3'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		DPD_ST_FREE = 3'b001,
		DPD_ST_LOCK = 3'b010,
		DPD_ST_HOLD = 3'b100
	} dpd_state_t;

	// Loop filter coefficients held in one profile, as right-shift amounts.
	typedef struct packed {
		logic [5:0] propShift;
		logic [5:0] intShift;
	} dpd_prof_t;

	// Processor side control bundle.
	typedef struct packed {
		logic wrFtw;
		logic [DPD_FTW_W-1:0] ftwData;
		logic holdUseAvg;
		logic autoHold;
		logic forceHold;
		logic wrProf;
		logic [2:0] wrProfIdx;
		dpd_prof_t wrProfData;
		logic [2:0] selProf;
		logic [2:0] selRef;
	} dpd_ctrl_t;

	// Status bundle back to the processor.
	typedef struct packed {
		logic [DPD_FTW_W-1:0] ftwActive;
		logic [DPD_FTW_W-1:0] ftwAverage;
		logic refPresent;
		logic inHold;
		logic locked;
	} dpd_stat_t;

endpackage

// >>> design/dpd_out_div.sv
// Programmable divider for one output pair, driven by the synthesizer carry enable.
// Assumes the carry enable is a one-cycle pulse on clk_sys.
`timescale 1ns/10ps
module dpd_out_div #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic enable,
	input wire logic [DIV_W-1:0] divide,
	input wire logic tickIn,
	// Output
	output logic clkOut
);
	logic [DIV_W-1:0] count_r;

	initial begin
		if (DIV_W < 2) begin
			$error("dpd_out_div: DIV_W must be at least 2");
		end
	end

	// A divide of zero bypasses the divider and passes the raw carry toggle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_r <= '0;
			clkOut <= 1'b0;
		end else if (!enable) begin
			count_r <= '0;
			clkOut <= 1'b0;
		end else if (tickIn) begin
			if (divide == '0 || count_r >= divide - 1'b1) begin
				count_r <= '0;
				clkOut <= ~clkOut;
			end else begin
				count_r <= count_r + 1'b1;
			end
		end
	end

endmodule

// >>> test/dpd_proc_model.sv
// Processor model on the control side: drives the control bundle and reads status back.
// Assumes clk_sys comes from the bench; every change lands just after a rising edge.
`timescale 1ns/10ps
module dpd_proc_model (
	// Clock
	input wire logic clk_sys,
	// Control and status
	output dpd_pkg::dpd_ctrl_t ctrl,
	input wire dpd_pkg::dpd_stat_t stat
);
	import dpd_pkg::*;

	initial ctrl = '0;

	// ****************************************
	// Requests
	// ****************************************
	// The word travels whole with its one-cycle strobe.
	task automatic write_ftw(input logic [DPD_FTW_W-1:0] w);
		@(posedge clk_sys);
		ctrl.ftwData <= w;
		ctrl.wrFtw <= 1'b1;
		@(posedge clk_sys);
		ctrl.wrFtw <= 1'b0;
	endtask

	task automatic read_ftw(output logic [DPD_FTW_W-1:0] w);
		@(posedge clk_sys);
		#1 w = stat.ftwActive;
	endtask

	task automatic write_prof(input logic [2:0] idx, input dpd_prof_t p);
		@(posedge clk_sys);
		ctrl.wrProfIdx <= idx;
		ctrl.wrProfData <= p;
		ctrl.wrProf <= 1'b1;
		@(posedge clk_sys);
		ctrl.wrProf <= 1'b0;
	endtask

	task automatic set_mode(input logic ah, input logic fh, input logic avg, input logic [2:0] prof,
		input logic [2:0] sel);
		@(posedge clk_sys);
		ctrl.autoHold <= ah;
		ctrl.forceHold <= fh;
		ctrl.holdUseAvg <= avg;
		ctrl.selProf <= prof;
		ctrl.selRef <= sel;
	endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the disciplined synthesizer loop.
// Assumes the loop is built with a short loss count and a small feedback divider.
`timescale 1ns/10ps
module tb;
	import dpd_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	localparam int LOSS = 16;
	typedef struct packed {
		logic [DPD_FTW_W-1:0] ftw;
		logic [DPD_FTW_W-1:0] expAct;
	} dpd_tb_row_t;
	localparam dpd_tb_row_t ROWS [4] = '{
		'{48'h0000_0000_0001, 48'h0000_0000_0001},
		'{48'h8000_0000_0000, 48'h8000_0000_0000},
		'{48'hffff_ffff_ffff, 48'hffff_ffff_ffff},
		'{48'h1234_5678_9abc, 48'h1234_5678_9abc}
	};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [DPD_NUM_REF-1:0] refIn = '0;
	logic [DPD_NUM_OUT-1:0] outEnable = '0;
	logic [DPD_NUM_OUT*DPD_DIV_W-1:0] outDivide = '0;
	logic [DPD_NUM_OUT-1:0] outClk;
	logic [DPD_NUM_OUT-1:0] lastClk;
	logic [DPD_FTW_W-1:0] synthPhase;
	logic [DPD_FTW_W-1:0] w;
	logic [DPD_FTW_W-1:0] p0;
	dpd_ctrl_t ctrl;
	dpd_stat_t stat;
	logic refRun = 1'b0;
	logic [2:0] refSel = 3'h0;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int edges [DPD_NUM_OUT];

	always #20 clk_sys = ~clk_sys;

	dpd_loop #(.LOSS_CYCLES(LOSS), .FB_DIV(2)) u_dpd_loop (.clk_sys(clk_sys), .rst(rst), .refIn(refIn),
		.outEnable(outEnable), .outDivide(outDivide), .outClk(outClk), .ctrl(ctrl), .stat(stat),
		.synthPhase(synthPhase));
	dpd_proc_model u_dpd_proc_model (.clk_sys(clk_sys), .ctrl(ctrl), .stat(stat));

	// Reference pin pulses high two cycles out of eight while running.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		refIn <= (refRun && (cycles % 8) < 2) ? (8'h01 << refSel) : 8'h00;
		if (cycles == 3000) begin
			fails++;
			final_report();
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	task automatic check_word(input logic [DPD_FTW_W-1:0] exp, input logic [DPD_FTW_W-1:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic check_bit(input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic final_report();
		$display("compared %0d, wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk_sys) rst <= 1'b1;
		repeat (12) @(posedge clk_sys);
		#1 check_word('0, synthPhase);
		check_bit(1'b0, |stat);
		check_bit(1'b0, |outClk);
		@(posedge clk_sys) rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 check_word(DPD_FTW_RST, stat.ftwActive);
		check_bit(1'b0, stat.locked);
	endtask

	task automatic check_step(input logic [DPD_FTW_W-1:0] f);
		repeat (3) @(posedge clk_sys);
		#1 p0 = synthPhase;
		@(posedge clk_sys);
		#1 check_word(f, synthPhase - p0);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		do_reset();
		for (int i = 0; i < 4; i++) begin
			u_dpd_proc_model.write_ftw(ROWS[i].ftw);
			repeat (2) @(posedge clk_sys);
			#1 check_word(ROWS[i].expAct, stat.ftwActive);
			u_dpd_proc_model.read_ftw(w);
			check_word(ROWS[i].expAct, w);
			check_step(ROWS[i].ftw);
		end
		// Half-scale word gives a carry every second cycle, so 16 toggles in 32 cycles.
		// Pair two divides the carries by two more, so it toggles only 8 times.
		u_dpd_proc_model.write_ftw(48'h8000_0000_0000);
		@(posedge clk_sys) outEnable <= 4'b0101;
		outDivide <= 32'h0002_0000;
		repeat (4) @(posedge clk_sys);
		#1 lastClk = outClk;
		edges = '{0, 0, 0, 0};
		repeat (32) begin
			@(posedge clk_sys);
			#1 for (int g = 0; g < DPD_NUM_OUT; g++) begin
				if (outClk[g] !== lastClk[g]) edges[g]++;
			end
			lastClk = outClk;
		end
		for (int g = 0; g < DPD_NUM_OUT; g++) check_word(g % 2 ? 48'd0 : (g == 2 ? 48'd8 : 48'd16), 48'(edges[g]));
		// Pulses on an unselected pin must not count as a reference.
		refSel = 3'h3;
		refRun = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1 check_bit(1'b0, stat.refPresent);
		u_dpd_proc_model.set_mode(1'b0, 1'b0, 1'b0, 3'h0, 3'h3);
		repeat (12) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.refPresent);
		check_bit(1'b1, stat.locked);
		u_dpd_proc_model.write_ftw(48'h0abc_0000_0123);
		@(posedge clk_sys);
		#1 check_bit(1'b1, stat.ftwActive !== 48'h0abc_0000_0123);
		u_dpd_proc_model.write_prof(3'h1, '{6'h08, 6'h10});
		u_dpd_proc_model.set_mode(1'b0, 1'b0, 1'b0, 3'h1, 3'h3);
		repeat (4) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.locked);
		// Loss without automatic holdover falls back to free run.
		refRun = 1'b0;
		repeat (LOSS + 8) @(posedge clk_sys);
		#1 check_bit(1'b0, stat.locked);
		check_bit(1'b0, stat.inHold);
		refRun = 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.locked);
		u_dpd_proc_model.set_mode(1'b1, 1'b0, 1'b0, 3'h1, 3'h3);
		refRun <= 1'b0;
		repeat (LOSS + 8) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.inHold);
		check_bit(1'b0, stat.refPresent);
		u_dpd_proc_model.write_ftw(48'h0000_1111_2222);
		repeat (2) @(posedge clk_sys);
		#1 check_word(48'h0000_1111_2222, stat.ftwActive);
		u_dpd_proc_model.set_mode(1'b1, 1'b0, 1'b1, 3'h1, 3'h3);
		repeat (4) @(posedge clk_sys);
		#1 check_word(stat.ftwAverage, stat.ftwActive);
		// Forced holdover keeps the loop open while a reference is present.
		u_dpd_proc_model.set_mode(1'b0, 1'b1, 1'b0, 3'h1, 3'h3);
		refRun <= 1'b1;
		repeat (16) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.inHold);
		check_bit(1'b1, stat.refPresent);
		u_dpd_proc_model.set_mode(1'b0, 1'b0, 1'b0, 3'h1, 3'h3);
		repeat (4) @(posedge clk_sys);
		#1 check_bit(1'b1, stat.locked);
		refRun <= 1'b0;
		do_reset();
		final_report();
	end
endmodule
